// ---- shared/fsw_pkg.sv ----
package fsw_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_CHK = 12'h008;
   localparam logic [11:0] ADDR_OUTD = 12'h00c;
   localparam logic [11:0] ADDR_PRESET = 12'h010;
   localparam logic [11:0] ADDR_TIME_LO = 12'h014;
   localparam logic [11:0] ADDR_TIME_HI = 12'h018;
   localparam logic [11:0] ADDR_MULT = 12'h400;
   localparam logic [11:0] ADDR_IF_WD = 12'h410;
   localparam logic [11:0] ADDR_PD_WD = 12'h420;
   // field positions
   localparam int CTRL_PD_EN = 3;
   localparam int CTRL_IF_EN = 4;
   localparam int CHK_MBX = 0;
   localparam int CHK_PD = 1;
   localparam int CHK_TIME = 2;
   localparam int CHK_TIME_USED = 3;
   localparam int STAT_ERR = 3;
   localparam int STAT_PD_TRIG = 4;
   localparam int STAT_IF_TRIG = 5;
   // reset values
   localparam logic [15:0] MULT_RST = 16'h09c2;
   localparam logic [15:0] PD_WD_RST = 16'h03e8;
   localparam logic [15:0] IF_WD_RST = 16'h03e8;
   localparam logic [4:0] CTRL_EN_RST = 5'h18;
   // timing
   localparam int CLK_NS = 10;
   localparam int BASE_TICK_NS = 40;
   localparam int BASE_CYC = (BASE_TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] MULT_EXTRA = 16'h0002;
   localparam logic [63:0] TIME_INC = 64'(CLK_NS);
   typedef enum logic [2:0] {
      FSW_INIT = 3'h0,
      FSW_PREOP = 3'h1,
      FSW_SAFEOP = 3'h3,
      FSW_OP = 3'h2,
      FSW_BOOT = 3'h6
   } fsw_state_t;
endpackage

// ---- tb/fsw_net.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsw_net (
   input wire logic clk_in, // bench clock
   output logic pd_req_out, // process data access
   output logic mbx_req_out, // mailbox access
   output logic mbx_ft_out // file-transfer qualifier
);
   initial begin
      pd_req_out = 1'b0;
      mbx_req_out = 1'b0;
      mbx_ft_out = 1'b0;
   end
   // one-cycle access; idle qualifier flips so a stale level is never trusted
   task automatic access(input logic pd, input logic mbx, input logic ft);
      @(posedge clk_in);
      pd_req_out <= pd;
      mbx_req_out <= mbx;
      mbx_ft_out <= ft;
      @(posedge clk_in);
      pd_req_out <= 1'b0;
      mbx_req_out <= 1'b0;
      mbx_ft_out <= ~ft;
   endtask
endmodule
`default_nettype wire

// ---- tb/fsw_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsw_top_tb;
   import fsw_pkg::*;
   logic clk, rst, psel, pen, pwr, lpi, pready, pslverr, err;
   logic pd_req, mbx_req, mbx_ft, pd_ack, mbx_ack, rej, pd_trig, if_trig;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] pins, image, phys;
   logic [1:0] en;
   logic [63:0] stime, t0;
   fsw_state_t state;
   int num_errors = 0;
   int n_tests = 0;
   int k;
   fsw_top fsw_top_i (.SYS_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PD_REQ_IN(pd_req), .MBX_REQ_IN(mbx_req),
      .MBX_FT_IN(mbx_ft), .LPI_ACCESS_IN(lpi), .PD_ACK_OUT(pd_ack), .MBX_ACK_OUT(mbx_ack),
      .REJECT_OUT(rej), .IN_PINS_IN(pins), .IN_IMAGE_OUT(image), .PHYS_OUT(phys),
      .STATE_OUT(state), .PD_WD_TRIG_OUT(pd_trig), .IF_WD_TRIG_OUT(if_trig),
      .SYS_TIME_OUT(stime));
   fsw_net fsw_net_i (.clk_in(clk), .pd_req_out(pd_req), .mbx_req_out(mbx_req),
      .mbx_ft_out(mbx_ft));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test;
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      w = 0;
      // no local limit: only the bench watchdog may end this wait
      do begin
         @(posedge clk);
         w++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      pwdata <= ~d;
      chk(w, 2); // slave inserts exactly one wait state
   endtask
   // state request, then state and error flag after the fixed one-cycle answer
   task automatic go(input logic [2:0] s, input fsw_state_t exp, input logic e);
      apb(1'b1, ADDR_CTRL, {27'h0, en, s});
      repeat (3) @(posedge clk);
      chk(state, exp);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_ERR], e);
   endtask
   task automatic traf(input logic p, input logic m, input logic f, input logic ok);
      fsw_net_i.access(p, m, f);
      #1;
      chk({pd_ack, mbx_ack, rej}, {p & ok, m & ok, ~ok});
   endtask
   task automatic t_reset;
      chk(state, FSW_INIT);
      apb(1'b0, ADDR_MULT, 32'h0);
      chk(rd, 32'h0000_09c2);
      apb(1'b0, ADDR_PD_WD, 32'h0);
      chk(rd, 32'h0000_03e8);
      apb(1'b0, ADDR_IF_WD, 32'h0);
      chk(rd, 32'h0000_03e8);
      apb(1'b0, 12'h0fc, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      traf(1'b1, 1'b0, 1'b0, 1'b0);
      traf(1'b0, 1'b1, 1'b0, 1'b0);
      go(3'h5, FSW_INIT, 1'b1);
   endtask
   task automatic t_preop;
      go(3'h1, FSW_INIT, 1'b1);
      apb(1'b1, ADDR_CHK, 32'h1);
      go(3'h1, FSW_PREOP, 1'b0);
      traf(1'b0, 1'b1, 1'b0, 1'b1);
      traf(1'b1, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic t_safeop;
      apb(1'b1, ADDR_PRESET, 32'hc3);
      apb(1'b1, ADDR_OUTD, 32'h3c);
      go(3'h3, FSW_PREOP, 1'b1);
      apb(1'b1, ADDR_CHK, 32'hb);
      go(3'h3, FSW_PREOP, 1'b1);
      apb(1'b1, ADDR_CHK, 32'hf);
      go(3'h3, FSW_SAFEOP, 1'b0);
      chk(image, 8'h5a);
      chk(phys, 8'hc3);
      traf(1'b1, 1'b0, 1'b0, 1'b1);
      traf(1'b0, 1'b1, 1'b0, 1'b1);
      pins <= 8'ha5;
      repeat (20) @(posedge clk);
      chk(image, 8'ha5);
   endtask
   task automatic t_op;
      go(3'h2, FSW_OP, 1'b0);
      chk(phys, 8'h3c);
      traf(1'b1, 1'b0, 1'b0, 1'b1);
      traf(1'b0, 1'b1, 1'b0, 1'b1);
   endtask
   // multiplier 0 gives a tick of 2 base ticks of 4 clocks
   task automatic t_pdwd;
      apb(1'b1, ADDR_MULT, 32'h0);
      apb(1'b1, ADDR_PD_WD, 32'h3);
      traf(1'b1, 1'b0, 1'b0, 1'b1);
      for (k = 0; pd_trig !== 1'b1 && k < 100; k++) @(posedge clk);
      chk(k >= 16 && k <= 27, 1'b1);
      @(posedge clk);
      #1;
      chk(phys, 8'hc3);
      traf(1'b1, 1'b0, 1'b0, 1'b1);
      @(posedge clk);
      #1;
      chk({pd_trig, state, phys}, {1'b0, FSW_OP, 8'h3c});
   endtask
   task automatic t_pdoff;
      apb(1'b1, ADDR_PD_WD, 32'h0);
      traf(1'b1, 1'b0, 1'b0, 1'b1);
      repeat (60) @(posedge clk);
      chk({pd_trig, phys}, {1'b0, 8'h3c});
      en = 2'h2;
      go(3'h3, FSW_SAFEOP, 1'b0);
      chk(phys, 8'h3c);
      en = 2'h3;
      go(3'h2, FSW_OP, 1'b0);
   endtask
   task automatic t_ifwd;
      apb(1'b1, ADDR_IF_WD, 32'h2);
      @(posedge clk);
      lpi <= 1'b1;
      @(posedge clk);
      lpi <= 1'b0;
      for (k = 0; if_trig !== 1'b1 && k < 100; k++) @(posedge clk);
      chk(k >= 7 && k <= 19, 1'b1);
      lpi <= 1'b1;
      @(posedge clk);
      lpi <= 1'b0;
      repeat (2) @(posedge clk);
      chk(if_trig, 1'b0);
   endtask
   task automatic t_boot;
      go(3'h6, FSW_OP, 1'b1);
      go(3'h0, FSW_INIT, 1'b0);
      go(3'h6, FSW_BOOT, 1'b0);
      traf(1'b0, 1'b1, 1'b1, 1'b1);
      traf(1'b0, 1'b1, 1'b0, 1'b0);
      traf(1'b1, 1'b0, 1'b0, 1'b0);
      go(3'h1, FSW_BOOT, 1'b1);
   endtask
   task automatic t_time;
      @(posedge clk);
      #1;
      t0 = stime;
      repeat (5) @(posedge clk);
      #1;
      chk(stime - t0, 64'h32);
      apb(1'b1, ADDR_TIME_HI, 32'h1);
      apb(1'b1, ADDR_TIME_LO, 32'h100);
      #1;
      chk(stime, 64'h0000_0001_0000_0100);
      apb(1'b0, ADDR_TIME_HI, 32'h0);
      chk(rd, 32'h1);
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      lpi = 1'b0;
      pins = 8'h5a;
      en = 2'h3;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_preop();
      t_safeop();
      t_op();
      t_pdwd();
      t_pdoff();
      t_ifwd();
      t_time();
      t_boot();
      stop_test();
   end
   // the whole sequence needs a few hundred cycles
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire

// ---- verilog/fsw_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsw_top #(
   parameter int IO_W = 8,
   parameter int TIME_W = 64
) (
   input wire logic SYS_CLK_IN, // 100 MHz clock
   input wire logic RESET_IN, // async reset, active high
   input wire logic PSEL_IN, // apb select
   input wire logic PENABLE_IN, // apb enable
   input wire logic PWRITE_IN, // apb direction
   input wire logic [11:0] PADDR_IN, // apb byte address
   input wire logic [31:0] PWDATA_IN, // apb write data
   output logic [31:0] PRDATA_OUT, // apb read data
   output logic PREADY_OUT, // apb ready
   output logic PSLVERR_OUT, // apb error on unmapped
   input wire logic PD_REQ_IN, // network process data access
   input wire logic MBX_REQ_IN, // network mailbox access
   input wire logic MBX_FT_IN, // mailbox access is file transfer
   input wire logic LPI_ACCESS_IN, // local interface access
   output logic PD_ACK_OUT, // process access accepted
   output logic MBX_ACK_OUT, // mailbox access accepted
   output logic REJECT_OUT, // access refused
   input wire logic [IO_W-1:0] IN_PINS_IN, // physical inputs
   output logic [IO_W-1:0] IN_IMAGE_OUT, // input image in memory
   output logic [IO_W-1:0] PHYS_OUT, // physical outputs
   output fsw_pkg::fsw_state_t STATE_OUT, // communication state
   output logic PD_WD_TRIG_OUT, // process watchdog tripped
   output logic IF_WD_TRIG_OUT, // interface watchdog tripped
   output logic [TIME_W-1:0] SYS_TIME_OUT // local system time, ns
);
   import fsw_pkg::*;

   fsw_state_t state_r;
   logic [2:0] req_state_r;
   logic req_r;
   logic err_r;
   logic pd_en_r, if_en_r;
   logic [3:0] chk_r;
   logic [15:0] mult_r, pd_lim_r, if_lim_r;
   logic [IO_W-1:0] out_data_r, preset_r, img_r;
   logic [IO_W-1:0] sync1_r, sync2_r, sync3_r, in_stab_r;
   logic [TIME_W-1:0] time_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic [1:0] base_cnt_r;
   logic [15:0] tick_cnt_r, pd_cnt_r, if_cnt_r;
   logic wd_tick_r, pd_trig_r, if_trig_r;
   logic pd_ack_r, mbx_ack_r, rej_r;
   logic [IO_W-1:0] phys_r;

   logic acc, wr_done, mapped, pd_ok, mbx_ok, pd_wd_on, if_wd_on, legal;
   logic [31:0] rd_mux;
   logic [63:0] time64;

   assign acc = PSEL_IN & PENABLE_IN;
   assign wr_done = acc & pready_r & PWRITE_IN;
   assign time64 = 64'(time_r);
   assign pd_wd_on = pd_en_r & (pd_lim_r != 16'h0000);
   assign if_wd_on = if_en_r & (if_lim_r != 16'h0000);
   assign pd_ok = (state_r == FSW_SAFEOP) | (state_r == FSW_OP);
   assign mbx_ok = pd_ok | (state_r == FSW_PREOP) | ((state_r == FSW_BOOT) & MBX_FT_IN);

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (PADDR_IN)
         ADDR_CTRL: rd_mux = {27'h0, if_en_r, pd_en_r, req_state_r};
         ADDR_STAT: rd_mux = {26'h0, if_trig_r, pd_trig_r, err_r, state_r};
         ADDR_CHK: rd_mux = {28'h0, chk_r};
         ADDR_OUTD: rd_mux = 32'(out_data_r);
         ADDR_PRESET: rd_mux = 32'(preset_r);
         ADDR_TIME_LO: rd_mux = time64[31:0];
         ADDR_TIME_HI: rd_mux = time64[63:32];
         ADDR_MULT: rd_mux = {16'h0, mult_r};
         ADDR_IF_WD: rd_mux = {16'h0, if_lim_r};
         ADDR_PD_WD: rd_mux = {16'h0, pd_lim_r};
         default: mapped = 1'b0;
      endcase
   end

   // two-cycle access: ready is registered, write lands at the ready edge
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= acc & ~pready_r;
         pslverr_r <= acc & ~pready_r & ~mapped;
         if (acc & ~pready_r & ~PWRITE_IN) begin
            prdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         req_r <= 1'b0;
         req_state_r <= 3'h0;
         pd_en_r <= CTRL_EN_RST[CTRL_PD_EN];
         if_en_r <= CTRL_EN_RST[CTRL_IF_EN];
         chk_r <= 4'h0;
         out_data_r <= '0;
         preset_r <= '0;
         mult_r <= MULT_RST;
         pd_lim_r <= PD_WD_RST;
         if_lim_r <= IF_WD_RST;
      end else begin
         req_r <= wr_done & (PADDR_IN == ADDR_CTRL);
         if (wr_done) begin
            unique case (PADDR_IN)
               ADDR_CTRL: begin
                  req_state_r <= PWDATA_IN[2:0];
                  pd_en_r <= PWDATA_IN[CTRL_PD_EN];
                  if_en_r <= PWDATA_IN[CTRL_IF_EN];
               end
               ADDR_CHK: chk_r <= PWDATA_IN[3:0];
               ADDR_OUTD: out_data_r <= PWDATA_IN[IO_W-1:0];
               ADDR_PRESET: preset_r <= PWDATA_IN[IO_W-1:0];
               ADDR_MULT: mult_r <= PWDATA_IN[15:0];
               ADDR_IF_WD: if_lim_r <= PWDATA_IN[15:0];
               ADDR_PD_WD: pd_lim_r <= PWDATA_IN[15:0];
               default: ;
            endcase
         end
      end
   end

   // legality of the requested change, including its configuration checks
   always_comb begin
      legal = 1'b0;
      unique case (state_r)
         FSW_INIT: legal = (req_state_r == FSW_INIT) | (req_state_r == FSW_BOOT)
            | ((req_state_r == FSW_PREOP) & chk_r[CHK_MBX]);
         FSW_PREOP: legal = (req_state_r == FSW_INIT) | (req_state_r == FSW_PREOP)
            | ((req_state_r == FSW_SAFEOP) & chk_r[CHK_PD]
            & (~chk_r[CHK_TIME_USED] | chk_r[CHK_TIME]));
         FSW_SAFEOP: legal = (req_state_r != FSW_BOOT);
         FSW_OP: legal = (req_state_r != FSW_BOOT);
         FSW_BOOT: legal = (req_state_r == FSW_INIT) | (req_state_r == FSW_BOOT);
         default: legal = 1'b0;
      endcase
      if ((req_state_r == 3'h4) | (req_state_r == 3'h5) | (req_state_r == 3'h7)) begin
         legal = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         state_r <= FSW_INIT;
         err_r <= 1'b0;
      end else if (req_r) begin
         err_r <= ~legal;
         if (legal) begin
            state_r <= fsw_state_t'(req_state_r);
         end
      end
   end

   // pins pass three flops; a level counts once the last two agree
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         in_stab_r <= '0;
         img_r <= '0;
      end else begin
         sync1_r <= IN_PINS_IN;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         if (sync2_r == sync3_r) begin
            in_stab_r <= sync3_r;
         end
         // copy lands on the same edge the state turns safe_operational_state
         if (pd_ok | (req_r & legal & (state_r == FSW_PREOP)
               & (req_state_r == FSW_SAFEOP))) begin
            img_r <= in_stab_r;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         base_cnt_r <= 2'h0;
         tick_cnt_r <= 16'h0;
         wd_tick_r <= 1'b0;
      end else begin
         wd_tick_r <= 1'b0;
         base_cnt_r <= (base_cnt_r == 2'(BASE_CYC - 1)) ? 2'h0 : base_cnt_r + 2'h1;
         if (base_cnt_r == 2'(BASE_CYC - 1)) begin
            if (tick_cnt_r >= mult_r + MULT_EXTRA - 16'h1) begin
               tick_cnt_r <= 16'h0;
               wd_tick_r <= 1'b1;
            end else begin
               tick_cnt_r <= tick_cnt_r + 16'h1;
            end
         end
      end
   end

   // tick phase is free-running, so a timeout lands within one tick early
   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         pd_cnt_r <= 16'h0;
         pd_trig_r <= 1'b0;
      end else if (PD_REQ_IN & pd_ok) begin
         pd_cnt_r <= 16'h0;
         pd_trig_r <= 1'b0;
      end else if (~pd_wd_on) begin
         pd_cnt_r <= 16'h0;
         pd_trig_r <= 1'b0;
      end else if (wd_tick_r) begin
         if (pd_cnt_r >= pd_lim_r - 16'h1) begin
            pd_trig_r <= 1'b1;
         end else begin
            pd_cnt_r <= pd_cnt_r + 16'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         if_cnt_r <= 16'h0;
         if_trig_r <= 1'b0;
      end else if (LPI_ACCESS_IN | ~if_wd_on) begin
         if_cnt_r <= 16'h0;
         if_trig_r <= 1'b0;
      end else if (wd_tick_r) begin
         if (if_cnt_r >= if_lim_r - 16'h1) begin
            if_trig_r <= 1'b1;
         end else begin
            if_cnt_r <= if_cnt_r + 16'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         pd_ack_r <= 1'b0;
         mbx_ack_r <= 1'b0;
         rej_r <= 1'b0;
         phys_r <= '0;
      end else begin
         pd_ack_r <= PD_REQ_IN & pd_ok;
         mbx_ack_r <= MBX_REQ_IN & mbx_ok;
         rej_r <= (PD_REQ_IN & ~pd_ok) | (MBX_REQ_IN & ~mbx_ok);
         if (pd_trig_r | if_trig_r) begin
            phys_r <= preset_r;
         end else if ((state_r == FSW_OP) | ((state_r == FSW_SAFEOP) & ~pd_wd_on)) begin
            phys_r <= out_data_r;
         end else begin
            phys_r <= preset_r;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         time_r <= '0;
      end else if (wr_done & (PADDR_IN == ADDR_TIME_LO)) begin
         time_r <= TIME_W'({time64[63:32], PWDATA_IN});
      end else if (wr_done & (PADDR_IN == ADDR_TIME_HI)) begin
         time_r <= TIME_W'({PWDATA_IN, time64[31:0]});
      end else begin
         time_r <= time_r + TIME_W'(TIME_INC);
      end
   end

   assign PRDATA_OUT = prdata_r;
   assign PREADY_OUT = pready_r;
   assign PSLVERR_OUT = pslverr_r;
   assign PD_ACK_OUT = pd_ack_r;
   assign MBX_ACK_OUT = mbx_ack_r;
   assign REJECT_OUT = rej_r;
   assign IN_IMAGE_OUT = img_r;
   assign PHYS_OUT = phys_r;
   assign STATE_OUT = state_r;
   assign PD_WD_TRIG_OUT = pd_trig_r;
   assign IF_WD_TRIG_OUT = if_trig_r;
   assign SYS_TIME_OUT = time_r;

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (RESET_IN);

   boot_entry_a: assert property ($changed(state_r) && state_r == FSW_BOOT
      |-> $past(state_r) == FSW_INIT) else $error("boot not from init");
   preop_chk_a: assert property ($past(state_r) == FSW_INIT && state_r == FSW_PREOP
      |-> $past(chk_r[CHK_MBX])) else $error("pre_operational_state without mailbox check");
   safeop_chk_a: assert property ($past(state_r) == FSW_PREOP && state_r == FSW_SAFEOP
      |-> $past(chk_r[CHK_PD])) else $error("safe_operational_state without channel check");
   init_rej_a: assert property (state_r == FSW_INIT && PD_REQ_IN && !req_r
      |=> REJECT_OUT && !PD_ACK_OUT) else $error("init accepted traffic");
   preop_pd_a: assert property (state_r == FSW_PREOP && PD_REQ_IN && !req_r
      |=> !PD_ACK_OUT && REJECT_OUT) else $error("pre_operational_state accepted data");
   boot_mbx_a: assert property (state_r == FSW_BOOT && MBX_REQ_IN && !req_r
      |=> MBX_ACK_OUT == $past(MBX_FT_IN)) else $error("boot mailbox wrong");
   fail_hold_a: assert property (req_r && !legal
      |=> $stable(state_r) && err_r) else $error("failed change moved");
   trip_safe_a: assert property (pd_trig_r ##1 pd_trig_r
      |-> PHYS_OUT == $past(preset_r)) else $error("outputs not preset");
   pd_clear_a: assert property (PD_REQ_IN && pd_ok
      |=> !pd_trig_r && pd_cnt_r == 16'h0) else $error("access kept trip");
   pd_off_a: assert property (pd_lim_r == 16'h0 |=> !pd_trig_r)
      else $error("zero count tripped");
   if_alive_a: assert property (LPI_ACCESS_IN |=> !if_trig_r)
      else $error("interface trip despite access");
   time_step_a: assert property (!wr_done |=> time_r == $past(time_r) + TIME_W'(TIME_INC))
      else $error("time step wrong");
   op_out_a: assert property (state_r == FSW_OP && !pd_trig_r && !if_trig_r ##1
      $stable(state_r) |-> PHYS_OUT == $past(out_data_r)) else $error("op outputs");

   op_reach_c: cover property (state_r == FSW_OP);
   boot_reach_c: cover property (state_r == FSW_BOOT);
   pd_trip_c: cover property (pd_trig_r && state_r == FSW_OP);
   refuse_c: cover property (req_r && !legal);
endmodule
`default_nettype wire
